/* logic/csi_top.sv */
// Counter pin mux, voltage-sense and standby control with an APB slave.
// Assumes synchronous pin inputs and a single 250 MHz pclk domain.
`include "csi_params.svh"

// Summary of operation
// - With selector 3, io select bit 3 sends the high pin to the counter at 0, to input at 1.
// - With selector 3, io select bit 2 sends the low pin to the counter at 0, to input at 1.
// - Setup bits 3:2 pick high-pin frequency 00, low-pin frequency 01, low-pin period 10.
// - A count time is chosen first and counting starts only on the control instruction.
// - The count-done flag sets when a frequency or period count ends.
// - Internal register 0eh shows the high pin on bit 0 and the low pin on bit 1.
// - In clock stop both counter pins are disabled and pulled down.
// - After reset both pins are counter inputs and the mode is high-pin frequency.
// - Bit-test bit 3 shows the voltage-sense pin level.
// - The voltage-sense input stays enabled in clock stop and in reset.
// - With standby armed, a low standby pin blocks both oscillator inputs and floats the pump.
// - Clock stop is entered with arm set, standby pin low and the stop instruction.
// - A high standby pin releases clock stop.
module csi_top #(
    parameter int unsigned CNT_W = 20,
    parameter int unsigned GATE_W = 26
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic high_freq_counter_pin,
    input wire logic low_freq_counter_pin,
    input wire logic voltage_sense_pin,
    input wire logic standby_pin,
    input wire logic fm_oscillator_pin,
    input wire logic am_oscillator_pin,
    // Pin conditioning
    output logic high_pin_in_en,
    output logic low_pin_in_en,
    output logic high_pin_pulldown,
    output logic low_pin_pulldown,
    output logic fm_osc_in_en,
    output logic am_osc_in_en,
    output logic charge_pump_oe,
    output logic clock_stopped,
    // Counter view
    output csi_pkg::csi_mode_t count_mode,
    output logic count_done_flag
);
    import csi_pkg::*;

    initial
    begin
        if (CNT_W < 4 || CNT_W > 32 || GATE_W < 18 || GATE_W > 31)
            $error("csi_top: unsupported parameter values");
    end

    function automatic logic csi_hit(input logic [11:0] a, input logic [11:0] ofs);
        csi_hit = (a == ofs);
    endfunction : csi_hit

    logic wr_en;
    logic rd_en;
    logic stop_q;
    logic hsel_gp_q;
    logic lsel_gp_q;
    csi_mode_t mode_q;
    logic [3:0] ctime_q;
    logic ctime_ok_q;
    logic arm_q;
    logic sense_ff_q;
    logic done_q;
    logic [CNT_W-1:0] count_q;
    csi_cnt_st_t st_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic hin;
    logic lin;
    logic meas_in;
    logic meas_rise;
    logic gate_busy;
    logic gate_end;
    logic start_cmd;
    logic stop_cmd;
    logic [GATE_W-1:0] gate_len;
    logic mapped;

    // One wait state; a write lands on the edge where the master sees pready
    assign wr_en = psel && penable && pwrite && pready_q;
    assign rd_en = psel && penable && !pwrite && !pready_q;
    assign mapped = csi_hit(paddr, `CSI_OFS_IOSEL) || csi_hit(paddr, `CSI_OFS_UCSET) ||
        csi_hit(paddr, `CSI_OFS_UCCTL) || csi_hit(paddr, `CSI_OFS_INREG) ||
        csi_hit(paddr, `CSI_OFS_BTEST) || csi_hit(paddr, `CSI_OFS_STBY) ||
        csi_hit(paddr, `CSI_OFS_STAT) || csi_hit(paddr, `CSI_OFS_CTIME);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
        end
    end

    // Io select: only selector 3 touches the counter pin routing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hsel_gp_q <= 1'b0;
            lsel_gp_q <= 1'b0;
        end
        else if (wr_en && csi_hit(paddr, `CSI_OFS_IOSEL) && pwdata[7:4] == `CSI_PW_CTR)
        begin
            hsel_gp_q <= pwdata[`CSI_BIT_HSEL];
            lsel_gp_q <= pwdata[`CSI_BIT_LSEL];
        end
    end

    // Illegal code 11 is ignored, leaving the previous mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= csi_mode_t'(`CSI_MODE_RST);
        else if (wr_en && csi_hit(paddr, `CSI_OFS_UCSET)
            && pwdata[`CSI_BIT_MODE_HI:`CSI_BIT_MODE_LO] != CSI_MODE_BAD)
            mode_q <= csi_mode_t'(pwdata[`CSI_BIT_MODE_HI:`CSI_BIT_MODE_LO]);
    end

    // Count time is the code plus 1, in ms; a valid time must be chosen before starting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctime_q <= `CSI_CTIME_RST;
            ctime_ok_q <= 1'b0;
        end
        else if (wr_en && csi_hit(paddr, `CSI_OFS_CTIME))
        begin
            ctime_q <= pwdata[3:0];
            ctime_ok_q <= pwdata[`CSI_BIT_CTIME_VLD];
        end
    end

    assign gate_len = GATE_W'(`CSI_CYC_PER_MS) * GATE_W'(ctime_q + 4'h1);

    // Start only from a control write after the count time is valid
    assign start_cmd = wr_en && csi_hit(paddr, `CSI_OFS_UCCTL) && pwdata[`CSI_BIT_START]
        && ctime_ok_q && !stop_q;
    assign stop_cmd = wr_en && csi_hit(paddr, `CSI_OFS_STBY) && pwdata[`CSI_BIT_STOP];

    // Gated pin levels: disabled inputs read low, like a pulled-down pin
    assign hin = high_freq_counter_pin && !stop_q;
    assign lin = low_freq_counter_pin && !stop_q;
    assign meas_in = (mode_q == CSI_MODE_FREQ_H) ? (hin && !hsel_gp_q) : (lin && !lsel_gp_q);

    csi_edge_det u_edge
    (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(meas_in),
        .rise(meas_rise)
    );

    csi_gate_timer #(
        .W(GATE_W)
    ) u_gate
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_cmd && mode_q != CSI_MODE_PERIOD_L),
        .abort(stop_q),
        .length(gate_len),
        .busy(gate_busy),
        .expire(gate_end)
    );

    // Frequency: rising edges inside the gate; period: cycles from the start to the next rising edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= CSI_CNT_IDLE;
            count_q <= '0;
        end
        else if (start_cmd)
        begin
            st_q <= CSI_CNT_RUN;
            count_q <= '0;
        end
        else if (stop_q)
            st_q <= CSI_CNT_IDLE;
        else
        begin
            unique case (st_q)
                CSI_CNT_IDLE:
                    st_q <= CSI_CNT_IDLE;
                CSI_CNT_RUN:
                begin
                    if (mode_q == CSI_MODE_PERIOD_L)
                    begin
                        if (meas_rise)
                            st_q <= CSI_CNT_DONE;
                        else if (count_q != CNT_W'(`CSI_PERIOD_CAP))
                            count_q <= count_q + CNT_W'(1);
                    end
                    else
                    begin
                        if (meas_rise && gate_busy)
                            count_q <= count_q + CNT_W'(1);
                        if (gate_end)
                            st_q <= CSI_CNT_DONE;
                    end
                end
                CSI_CNT_DONE:
                    st_q <= CSI_CNT_IDLE;
                default:
                    st_q <= CSI_CNT_IDLE;
            endcase
        end
    end

    // Completion wins over a start in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_q <= 1'b0;
        else if (st_q == CSI_CNT_DONE)
            done_q <= 1'b1;
        else if (start_cmd)
            done_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            arm_q <= 1'b0;
        else if (wr_en && csi_hit(paddr, `CSI_OFS_STBY))
            arm_q <= pwdata[`CSI_BIT_ARM];
    end

    // Clock stop entry needs arm and a low pin; a high pin releases it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stop_q <= 1'b0;
        else if (standby_pin)
            stop_q <= 1'b0;
        else if (stop_cmd && arm_q)
            stop_q <= 1'b1;
    end

    // Sense flip-flop: sensed low while stopped marks a failure; a write of 1 clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sense_ff_q <= 1'b0;
        else if (stop_q && !voltage_sense_pin)
            sense_ff_q <= 1'b1;
        else if (wr_en && csi_hit(paddr, `CSI_OFS_BTEST) && pwdata[`CSI_BIT_SENSE])
            sense_ff_q <= 1'b0;
    end

    // Pin conditioning outputs, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_pin_in_en <= 1'b1;
            low_pin_in_en <= 1'b1;
            high_pin_pulldown <= 1'b0;
            low_pin_pulldown <= 1'b0;
            fm_osc_in_en <= 1'b0;
            am_osc_in_en <= 1'b0;
            charge_pump_oe <= 1'b0;
        end
        else
        begin
            high_pin_in_en <= !stop_q;
            low_pin_in_en <= !stop_q;
            high_pin_pulldown <= stop_q;
            low_pin_pulldown <= stop_q;
            fm_osc_in_en <= !(arm_q && !standby_pin) && !stop_q;
            am_osc_in_en <= !(arm_q && !standby_pin) && !stop_q;
            charge_pump_oe <= !(arm_q && !standby_pin) && !stop_q;
        end
    end

    // Read mux; sense level is read raw so it works even when stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= '0;
        else if (rd_en)
        begin
            prdata_q <= '0;
            if (csi_hit(paddr, `CSI_OFS_IOSEL))
                prdata_q <= {28'h0, hsel_gp_q, lsel_gp_q, 2'h0};
            else if (csi_hit(paddr, `CSI_OFS_UCSET))
                prdata_q <= {28'h0, mode_q, 2'h0};
            else if (csi_hit(paddr, `CSI_OFS_INREG))
            begin
                // Internal register 0eh view; a pin in counter use reads low
                prdata_q[`CSI_BIT_GPIN_H] <= hin && hsel_gp_q;
                prdata_q[`CSI_BIT_GPIN_L] <= lin && lsel_gp_q;
            end
            else if (csi_hit(paddr, `CSI_OFS_BTEST))
                prdata_q <= {28'h0, voltage_sense_pin, sense_ff_q, 2'h0};
            else if (csi_hit(paddr, `CSI_OFS_STBY))
                prdata_q <= {30'h0, stop_q, arm_q};
            else if (csi_hit(paddr, `CSI_OFS_STAT))
                prdata_q <= {done_q, (st_q == CSI_CNT_RUN), 10'h0, 20'(count_q)};
            else if (csi_hit(paddr, `CSI_OFS_CTIME))
                prdata_q <= {27'h0, ctime_ok_q, ctime_q};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign clock_stopped = stop_q;
    assign count_mode = mode_q;
    assign count_done_flag = done_q;

    done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == CSI_CNT_DONE |=> done_q) else $error("done flag not set");
    done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_cmd && st_q != CSI_CNT_DONE |=> !done_q) else $error("done not cleared");
    start_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_q == CSI_CNT_RUN) |-> $past(ctime_ok_q)) else $error("start w/o time");
    stop_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(stop_q) |-> $past(arm_q) && !$past(standby_pin)) else $error("bad stop");
    stop_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        standby_pin |=> !stop_q) else $error("stop not released");
    pin_pulldown_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop_q |=> high_pin_pulldown && low_pin_pulldown && !high_pin_in_en)
        else $error("pulldown");
    osc_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        arm_q && !standby_pin |=> !fm_osc_in_en && !am_osc_in_en && !charge_pump_oe)
        else $error("osc not blocked");
    sense_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop_q && !voltage_sense_pin |=> sense_ff_q) else $error("sense ff");
endmodule : csi_top

/* logic/csi_params.svh */
// Constants for the counter, sense and standby input block.
// Assumes a 32-bit APB slave clocked by pclk at 250 MHz.
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH

`define CSI_OFS_IOSEL 12'h000
`define CSI_OFS_UCSET 12'h004
`define CSI_OFS_UCCTL 12'h008
`define CSI_OFS_INREG 12'h00c
`define CSI_OFS_BTEST 12'h010
`define CSI_OFS_STBY 12'h014
`define CSI_OFS_STAT 12'h018
`define CSI_OFS_CTIME 12'h01c

`define CSI_PW_CTR 4'h3
`define CSI_INREG_ADDR 4'he
`define CSI_BIT_HSEL 3
`define CSI_BIT_LSEL 2
`define CSI_BIT_MODE_HI 3
`define CSI_BIT_MODE_LO 2
`define CSI_BIT_GPIN_H 0
`define CSI_BIT_GPIN_L 1
`define CSI_BIT_SENSE 2
`define CSI_BIT_SNSLVL 3
`define CSI_BIT_START 0
`define CSI_BIT_ARM 0
`define CSI_BIT_STOP 1
`define CSI_BIT_CTIME_VLD 4

`define CSI_MODE_RST 2'h0
`define CSI_CTIME_RST 4'h0
`define CSI_COUNT_MS_1 1
`define CSI_CLK_MHZ 250
`define CSI_CYC_PER_MS (`CSI_CLK_MHZ * 1000)
`define CSI_PERIOD_CAP 32'h000f_ffff

`endif

/* logic/csi_pkg.sv */
// Types shared by the counter, sense and standby input block.
// Assumes csi_params.svh supplies all numeric constants.
package csi_pkg;
    typedef enum logic [1:0]
    {
        CSI_MODE_FREQ_H = 2'b00,
        CSI_MODE_FREQ_L = 2'b01,
        CSI_MODE_PERIOD_L = 2'b10,
        CSI_MODE_BAD = 2'b11
    } csi_mode_t;

    typedef enum logic [1:0]
    {
        CSI_CNT_IDLE = 2'b00,
        CSI_CNT_RUN = 2'b01,
        CSI_CNT_DONE = 2'b10
    } csi_cnt_st_t;
endpackage : csi_pkg

/* logic/csi_edge_det.sv */
// Rising edge detector on an already synchronous level.
// Assumes the input is sampled on pclk.
module csi_edge_det
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in, pulse out
    input wire logic lvl,
    output logic rise
);
    logic lvl_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_q <= 1'b0;
        else
            lvl_q <= lvl;
    end

    assign rise = lvl & ~lvl_q;
endmodule : csi_edge_det

/* logic/csi_gate_timer.sv */
// Gate timer: counts a gate window of a programmed length in cycles.
// Assumes start is a single-cycle pulse.
module csi_gate_timer #(
    parameter int unsigned W = 26
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic [W-1:0] length,
    // Status
    output logic busy,
    output logic expire
);
    logic [W-1:0] cnt_q;
    logic busy_q;

    initial
    begin
        if (W < 2)
            $error("csi_gate_timer: W too small");
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end
        else if (abort)
            busy_q <= 1'b0;
        else if (start)
        begin
            cnt_q <= length;
            busy_q <= 1'b1;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - W'(1);
            if (cnt_q <= W'(1))
                busy_q <= 1'b0;
        end
    end

    assign busy = busy_q;
    assign expire = busy_q && (cnt_q <= W'(1)) && !abort;
endmodule : csi_gate_timer

/* sim/csi_pin_model.sv */
// Board-side sources for the counter, sense and standby pins.
// Assumes the bench sets levels and standby requests between edges.
module csi_pin_model
(
    // Clock
    input wire logic pclk,
    // Bench commands
    input wire logic toggle_en,
    input wire logic h_lvl,
    input wire logic l_lvl,
    input wire logic sense_lvl,
    input wire logic stby_low,
    // Pins
    output logic high_freq_counter_pin,
    output logic low_freq_counter_pin,
    output logic voltage_sense_pin,
    output logic standby_pin,
    output logic fm_oscillator_pin,
    output logic am_oscillator_pin
);
    logic [7:0] div_q = 8'h00;

    always_ff @(posedge pclk)
    begin
        div_q <= div_q + 8'h01;
    end

    // Slow low pin, so a period count can be seen to start first
    assign high_freq_counter_pin = toggle_en ? div_q[2] : h_lvl;
    assign low_freq_counter_pin = toggle_en ? div_q[5] : l_lvl;
    assign voltage_sense_pin = sense_lvl;
    assign standby_pin = !stby_low;
    assign fm_oscillator_pin = div_q[0];
    assign am_oscillator_pin = div_q[1];
endmodule : csi_pin_model

/* sim/testbench.sv */
// Self-checking bench for csi_top: APB reads queue their expectations.
// Assumes a one-wait-state APB slave and the block's register map.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import csi_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic tog = 1'b0, h_lvl = 1'b0, l_lvl = 1'b0, sense_lvl = 1'b1, stby_low = 1'b0;
    logic hp, lp, sp, stp, fp, ap;
    logic h_en, l_en, h_pd, l_pd, fm_en, am_en, cp_oe, stopped, done;
    csi_mode_t mode;
    int fails = 0;
    int cmp_count = 0;
    logic [31:0] q_exp[$], q_mask[$];
    logic q_err[$];

    always #2 pclk = ~pclk;

    csi_pin_model pins (.pclk(pclk), .toggle_en(tog), .h_lvl(h_lvl), .l_lvl(l_lvl),
        .sense_lvl(sense_lvl), .stby_low(stby_low), .high_freq_counter_pin(hp),
        .low_freq_counter_pin(lp), .voltage_sense_pin(sp), .standby_pin(stp),
        .fm_oscillator_pin(fp), .am_oscillator_pin(ap));

    csi_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .high_freq_counter_pin(hp),
        .low_freq_counter_pin(lp), .voltage_sense_pin(sp), .standby_pin(stp),
        .fm_oscillator_pin(fp), .am_oscillator_pin(ap), .high_pin_in_en(h_en),
        .low_pin_in_en(l_en), .high_pin_pulldown(h_pd), .low_pin_pulldown(l_pd),
        .fm_osc_in_en(fm_en), .am_osc_in_en(am_en), .charge_pump_oe(cp_oe),
        .clock_stopped(stopped), .count_mode(mode), .count_done_flag(done));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // Hold the request until pready is sampled high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 100)
            begin
                fails++;
                end_sim();
            end
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
        input logic err = 1'b0);
        q_exp.push_back(e);
        q_mask.push_back(m);
        q_err.push_back(err);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask : settle

    // Compares each completed read with the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && !pwrite && pready === 1'b1 && q_exp.size() > 0)
        begin
            chk(prdata & q_mask[0], q_exp[0]);
            chk({31'h0, pslverr}, {31'h0, q_err[0]});
            void'(q_exp.pop_front());
            void'(q_mask.pop_front());
            void'(q_err.pop_front());
        end
    end

    initial
    begin
        #200000;
        fails++;
        end_sim();
    end

    initial
    begin
        logic [1:0] lv;
        int n;
        void'($urandom(73));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk({30'h0, mode}, {30'h0, CSI_MODE_FREQ_H});
        chk({28'h0, h_en, l_en, h_pd, l_pd}, 32'hc);
        rd(`CSI_OFS_IOSEL, 32'h0, 32'hc);
        $display("test reset done");

        apb(1'b1, `CSI_OFS_UCSET, 32'h8);
        tog <= 1'b1;
        apb(1'b1, `CSI_OFS_UCCTL, 32'h1);
        repeat (100) @(posedge pclk);
        rd(`CSI_OFS_STAT, 32'h0, 32'hc000_0000);
        apb(1'b1, `CSI_OFS_CTIME, 32'h10);
        apb(1'b1, `CSI_OFS_UCCTL, 32'h1);
        n = 0;
        while (done !== 1'b1 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, done}, 32'h1);
        rd(`CSI_OFS_STAT, 32'h8000_0000, 32'h8000_0000);
        tog <= 1'b0;
        l_lvl <= 1'b0;
        apb(1'b1, `CSI_OFS_UCCTL, 32'h1);
        // Start lands on the pready edge; 20 quiet edges give a period of 20
        repeat (20) @(posedge pclk);
        chk({31'h0, done}, 32'h0);
        l_lvl <= 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, done}, 32'h1);
        rd(`CSI_OFS_STAT, 32'h8000_0014, 32'hc00f_ffff);
        apb(1'b1, `CSI_OFS_UCSET, 32'h0);
        apb(1'b1, `CSI_OFS_UCCTL, 32'h1);
        settle();
        rd(`CSI_OFS_STAT, 32'h4000_0000, 32'hc000_0000);
        tog <= 1'b0;
        $display("test count done");

        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `CSI_OFS_UCSET, i << 2);
            settle();
            chk({30'h0, mode}, (i == 3) ? 32'h2 : i);
        end
        $display("test modes done");

        apb(1'b1, `CSI_OFS_IOSEL, 32'h5c);
        h_lvl <= 1'b1;
        l_lvl <= 1'b1;
        settle();
        rd(`CSI_OFS_INREG, 32'h0, 32'h3);
        apb(1'b1, `CSI_OFS_IOSEL, 32'h3c);
        for (int i = 0; i < 4; i++)
        begin
            lv = 2'($urandom());
            h_lvl <= lv[0];
            l_lvl <= lv[1];
            settle();
            rd(`CSI_OFS_INREG, {30'h0, lv}, 32'h3);
        end
        apb(1'b1, `CSI_OFS_IOSEL, 32'h34);
        rd(`CSI_OFS_INREG, {30'h0, lv[1], 1'b0}, 32'h3);
        $display("test gpio done");

        settle();
        chk({29'h0, fm_en, am_en, cp_oe}, 32'h7);
        apb(1'b1, `CSI_OFS_STBY, 32'h1);
        stby_low <= 1'b1;
        settle();
        chk({29'h0, fm_en, am_en, cp_oe}, 32'h0);
        apb(1'b1, `CSI_OFS_STBY, 32'h3);
        settle();
        chk({31'h0, stopped}, 32'h1);
        rd(`CSI_OFS_STBY, 32'h2, 32'h2);
        chk({28'h0, h_en, l_en, h_pd, l_pd}, 32'h3);
        sense_lvl <= 1'b0;
        settle();
        rd(`CSI_OFS_BTEST, 32'h4, 32'hc);
        sense_lvl <= 1'b1;
        stby_low <= 1'b0;
        settle();
        chk({31'h0, stopped}, 32'h0);
        rd(`CSI_OFS_BTEST, 32'hc, 32'hc);
        apb(1'b1, `CSI_OFS_BTEST, 32'h4);
        rd(`CSI_OFS_BTEST, 32'h8, 32'hc);
        apb(1'b1, `CSI_OFS_STBY, 32'h0);
        stby_low <= 1'b1;
        apb(1'b1, `CSI_OFS_STBY, 32'h2);
        settle();
        chk({30'h0, stopped, fm_en}, 32'h1);
        stby_low <= 1'b0;
        $display("test standby done");

        rd(12'hffc, 32'h0, 32'hffff_ffff, 1'b1);
        $display("test unmapped done");
        end_sim();
    end
endmodule : testbench
